// ---- reset_sampler_consts.vh ----
// constants for the reset and mode sampler
`ifndef RESET_SAMPLER_CONSTS_VH
`define RESET_SAMPLER_CONSTS_VH
`define SAMPLE_WINDOW_CYCLES 10
`define SAMPLE_CNT_WIDTH 4
`define FETCH_DELAY_CYCLES 80
`define FETCH_CNT_WIDTH 7
`define SYNC_STAGES 2
`define BOOT_WIDTH_RESET 1'b0
`define TRISTATE_RESET 1'b0
`endif

// ---- reset_and_mode_sampler.v ----
// reset sequencer with reset-time mode latching and flash reset forwarding
`timescale 1ns/10ps
`include "reset_sampler_consts.vh"
module reset_and_mode_sampler (
    input wire clk,
    input wire arst_n,
    input wire external_reset_n,
    input wire watchdog_reset,
    input wire boot_width_select,
    input wire tristate_select_n,
    input wire flash_reset_n,
    input wire clock_out_as_gpio,
    output reg coreReset_n,
    output reg peripheralReset_n,
    output reg fetchEnable,
    output reg bootWidth8,
    output reg tristateMode,
    output reg outputDriverDisable,
    output reg flashDirectAccess,
    output reg flashReset_n,
    output reg remapClear,
    output reg peripheralPinsInput,
    output reg clockOutEnable
);
    // one-hot sequencer states
    localparam [2:0] ST_RESET = 3'b001;
    localparam [2:0] ST_DELAY = 3'b010;
    localparam [2:0] ST_RUN = 3'b100;

    reg [`SYNC_STAGES-1:0] releaseSync;
    reg [`SAMPLE_CNT_WIDTH-1:0] bootLowRun;
    reg [`SAMPLE_CNT_WIDTH-1:0] bootHighRun;
    reg [`SAMPLE_CNT_WIDTH-1:0] triLowRun;
    reg [`FETCH_CNT_WIDTH-1:0] fetchCount;
    reg [2:0] state;
    reg [2:0] next_state;
    reg extPrev;
    wire extRise;
    wire anyReset;

    // a run counter at the window length saw its level on every edge of the window
    function windowFull;
        input [`SAMPLE_CNT_WIDTH-1:0] cnt;
        begin
            windowFull = (cnt == `SAMPLE_WINDOW_CYCLES);
        end
    endfunction

    // saturating run-length step used by the pin samplers
    function [`SAMPLE_CNT_WIDTH-1:0] runStep;
        input [`SAMPLE_CNT_WIDTH-1:0] cnt;
        input cond;
        begin
            if (!cond) begin
                runStep = {`SAMPLE_CNT_WIDTH{1'b0}};
            end else if (windowFull(cnt)) begin
                runStep = cnt;
            end else begin
                runStep = cnt + 1'b1;
            end
        end
    endfunction

    // release edge of the external reset; pins are synchronous to clk
    assign extRise = external_reset_n && !extPrev;
    // either source asserts anyReset; watchdog merely joins external reset
    assign anyReset = !external_reset_n || watchdog_reset;

    // release synchronizer: asserts at once, releases after two edges
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            releaseSync <= {`SYNC_STAGES{1'b0}};
        end else if (anyReset) begin
            releaseSync <= {`SYNC_STAGES{1'b0}};
        end else begin
            releaseSync <= {releaseSync[`SYNC_STAGES-2:0], 1'b1};
        end
    end

    // pin level run lengths, counted only while external reset is low
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extPrev <= 1'b1; // idle level of the pin, so no false release edge
            bootLowRun <= {`SAMPLE_CNT_WIDTH{1'b0}};
            bootHighRun <= {`SAMPLE_CNT_WIDTH{1'b0}};
            triLowRun <= {`SAMPLE_CNT_WIDTH{1'b0}};
        end else begin
            extPrev <= external_reset_n;
            bootLowRun <= runStep(bootLowRun, !external_reset_n && !boot_width_select);
            bootHighRun <= runStep(bootHighRun, !external_reset_n && boot_width_select);
            triLowRun <= runStep(triLowRun, !external_reset_n && !tristate_select_n);
        end
    end

    // mode latches update only on an external release, never on watchdog
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bootWidth8 <= `BOOT_WIDTH_RESET;
            tristateMode <= `TRISTATE_RESET;
        end else if (extRise) begin
            // pin held high the whole window picks 8-bit, low picks 16-bit
            if (windowFull(bootHighRun)) begin
                bootWidth8 <= 1'b1;
            end else if (windowFull(bootLowRun)) begin
                bootWidth8 <= 1'b0;
            end
            tristateMode <= windowFull(triLowRun);
        end
    end

    // next state of the fetch sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: begin
                if (releaseSync[`SYNC_STAGES-1]) begin
                    next_state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (fetchCount == `FETCH_DELAY_CYCLES - `SYNC_STAGES - 1) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RESET;
            end
        endcase
    end

    // sequencer and fetch delay counter; any reset returns to start
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_RESET;
            fetchCount <= {`FETCH_CNT_WIDTH{1'b0}};
        end else if (anyReset) begin
            state <= ST_RESET;
            fetchCount <= {`FETCH_CNT_WIDTH{1'b0}};
        end else begin
            state <= next_state;
            if (state == ST_DELAY) begin
                fetchCount <= fetchCount + 1'b1;
            end
        end
    end

    // processor held until the fetch point, peripherals only until the fetch delay count starts
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            coreReset_n <= 1'b0;
            peripheralReset_n <= 1'b0;
            fetchEnable <= 1'b0;
        end else begin
            coreReset_n <= !anyReset && (next_state == ST_RUN);
            peripheralReset_n <= !anyReset && (state != ST_RESET);
            fetchEnable <= !anyReset && (next_state == ST_RUN);
        end
    end

    // latched tristate mode drives the driver disable and flash pass-through
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            outputDriverDisable <= 1'b0;
            flashDirectAccess <= 1'b0;
        end else begin
            outputDriverDisable <= tristateMode;
            flashDirectAccess <= tristateMode;
        end
    end

    // flash reset forwarded on its own, untouched by the processor reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flashReset_n <= 1'b0;
        end else begin
            flashReset_n <= flash_reset_n;
        end
    end

    // remap clear follows every reset source, nothing else clears it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            remapClear <= 1'b1;
        end else begin
            remapClear <= anyReset;
        end
    end

    // pin direction and master clock copy
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            peripheralPinsInput <= 1'b1;
            clockOutEnable <= 1'b1;
        end else begin
            peripheralPinsInput <= anyReset || (state != ST_RUN);
            // clock copy runs during reset until software frees the pin
            clockOutEnable <= anyReset || !clock_out_as_gpio;
        end
    end
endmodule

// ---- board_model.sv ----
// board reset button and mode straps
`timescale 1ns/10ps
module board_model (
    input wire clk, pressReset, bootLevel, triLevel,
    output reg external_reset_n = 1'h0,
    output wire boot_width_select, tristate_select_n
);
    // reset moves off the sampling edge, clock already running
    always @(negedge clk) external_reset_n <= !pressReset;
    // mode pin pulled up unless driven low
    assign tristate_select_n = triLevel !== 1'h0;
    assign boot_width_select = bootLevel;
endmodule

// ---- reset_and_mode_sampler_monitor.sv ----
// checks on the reset sampler ports
`timescale 1ns/10ps
module reset_and_mode_sampler_monitor (
    input wire clk, arst_n, external_reset_n, watchdog_reset, flash_reset_n,
    input wire clock_out_as_gpio, coreReset_n, peripheralReset_n, fetchEnable,
    input wire bootWidth8, tristateMode, outputDriverDisable, flashDirectAccess,
    input wire flashReset_n, remapClear, peripheralPinsInput, clockOutEnable
);
    // one clock, quiet in async reset
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_in; !external_reset_n |=> !coreReset_n && !fetchEnable; endproperty
    a_in: assert property (p_in) else $error("entry");
    property p_go; $rose(external_reset_n) && !watchdog_reset |->
        ##80 !fetchEnable ##1 fetchEnable; endproperty
    a_go: assert property (p_go) else $error("fetch");
    property p_wd; watchdog_reset && external_reset_n |=> $stable({bootWidth8, tristateMode});
    endproperty
    a_wd: assert property (p_wd) else $error("modes");
    property p_rs; !external_reset_n || watchdog_reset |=> !peripheralReset_n && remapClear;
    endproperty
    a_rs: assert property (p_rs) else $error("reset");
    property p_tri; tristateMode |=> outputDriverDisable && flashDirectAccess; endproperty
    a_tri: assert property (p_tri) else $error("tristate");
    property p_fl; !flash_reset_n |=> !flashReset_n; endproperty
    a_fl: assert property (p_fl) else $error("flash");
    property p_ck; !clock_out_as_gpio || !external_reset_n |=> clockOutEnable; endproperty
    a_ck: assert property (p_ck) else $error("clock out");
    property p_pin; $rose(external_reset_n) |=> peripheralPinsInput [*8]; endproperty
    a_pin: assert property (p_pin) else $error("pins");
endmodule
bind reset_and_mode_sampler reset_and_mode_sampler_monitor u_mon (.*);

// ---- testbench.sv ----
// bench for the reset and mode sampler
`timescale 1ns/10ps
module testbench;
    reg clk = 1'h0, arst_n = 1'h0, pressReset = 1'h1, bootLevel = 1'h0, triLevel = 1'h1;
    reg watchdog_reset = 1'h0, flash_reset_n = 1'h0, clock_out_as_gpio = 1'h0;
    wire external_reset_n, boot_width_select, tristate_select_n, coreReset_n, remapClear;
    wire peripheralReset_n, fetchEnable, bootWidth8, tristateMode, outputDriverDisable;
    wire flashDirectAccess, flashReset_n, peripheralPinsInput, clockOutEnable;
    integer n_tests = 0, n_mismatch = 0, cycles = 0;
    // bits: reset, watchdog, boot strap, tristate strap, expected boot 8, expected tristate
    localparam logic [5:0] rows [4] = '{6'h2e, 6'h24, 6'h2b, 6'h21};
    reset_and_mode_sampler u_dut (.*);
    board_model u_board (.*);
    // clock
    initial forever #2 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1500) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    // compare and count
    task check(input string what, input logic seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // hold reset n cycles, release, check fetch time and latched modes
    task cycle(input logic [5:0] c, input integer n);
        {pressReset, watchdog_reset, bootLevel, triLevel} <= c[5:2];
        repeat (n) @(negedge clk);
        check("core reset", coreReset_n, 1'h0);
        check("periph reset", peripheralReset_n, 1'h0);
        check("remap", remapClear, 1'h1);
        check("pins in", peripheralPinsInput, 1'h1);
        {pressReset, watchdog_reset} <= 2'h0;
        repeat (80) @(negedge clk);
        check("fetch", fetchEnable, 1'h0);
        repeat (2) @(negedge clk);
        check("fetch", fetchEnable, 1'h1);
        check("boot", bootWidth8, c[1]);
        check("tristate", tristateMode, c[0]);
        check("core reset", coreReset_n, 1'h1);
        @(negedge clk);
        check("pins in", peripheralPinsInput, 1'h0);
        check("remap", remapClear, 1'h0);
        check("periph reset", peripheralReset_n, 1'h1);
        check("drivers off", outputDriverDisable, c[0]);
        check("flash direct", flashDirectAccess, c[0]);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        {arst_n, flash_reset_n} <= 2'h3;
        foreach (rows[i]) cycle(rows[i], 12);
        // watchdog keeps modes, both resets sample, nine-edge straps ignored
        cycle(6'h1d, 12);
        cycle(6'h3e, 12);
        cycle(6'h22, 9);
        // flash reset and clock-out pin given to software while running
        {flash_reset_n, clock_out_as_gpio} <= 2'h1;
        repeat (2) @(negedge clk);
        check("flash", flashReset_n, 1'h0);
        check("clock out", clockOutEnable, 1'h0);
        // block reset in mid-run returns outputs at once, then recovers
        arst_n <= 1'h0;
        #1;
        check("core reset", coreReset_n, 1'h0);
        check("boot", bootWidth8, 1'h0);
        check("remap", remapClear, 1'h1);
        check("clock out", clockOutEnable, 1'h1);
        @(negedge clk);
        arst_n <= 1'h1;
        repeat (3) @(negedge clk);
        check("clock out", clockOutEnable, 1'h0);
        check("fetch", fetchEnable, 1'h0);
        check("pins in", peripheralPinsInput, 1'h1);
        check("tristate", tristateMode, 1'h0);
        report_and_stop;
    end
endmodule
